// ===== rtl/memmap_pkg.sv
// Constants, types and helpers shared by the memory map control block
package memmap_pkg;

  // ************************************************************
  // Register indexes (byte address is four times the index)
  // ************************************************************
  localparam logic [13:0] IDX_FLASH_CTRL_ONE    = 14'h0fd0;
  localparam logic [13:0] IDX_FLASH_CTRL_COMMIT = 14'h0fd1;
  localparam logic [13:0] IDX_RAM_MAP_CONTROL   = 14'h0fde;
  localparam logic [13:0] IDX_MAP_COMMIT_KEY    = 14'h0fdf;
  localparam logic [13:0] IDX_RESET_STATUS      = 14'h0fe0;
  localparam logic [13:0] IDX_SHADOW_VIEW       = 14'h0fe1;

  // ************************************************************
  // Key codes, field positions and reset values
  // ************************************************************
  localparam logic [7:0] KEY_MAP_COMMIT   = 8'hd4;
  localparam logic [7:0] KEY_RST_DISABLE  = 8'hb2;
  localparam logic [7:0] KEY_FLAG_CLEAR   = 8'h71;
  localparam logic [7:0] KEY_FLASH_COMMIT = 8'hd5;
  localparam int         RMC_RST_DIS_BIT  = 0;
  localparam int         RMC_RAM_CODE_BIT = 1;
  localparam int         RMC_VEC_BIT      = 2;
  localparam int         FC1_BOOT_BIT     = 3;
  localparam int         IRS_FLAG_CLR_BIT = 0;
  localparam logic [7:0] RMC_RESET        = 8'h00;
  localparam logic [7:0] FC1_RESET        = 8'h40;
  localparam logic [7:0] IRS_RESET        = 8'h00;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

  // ************************************************************
  // Address windows
  // ************************************************************
  localparam logic [15:0] SFR1_LO  = 16'h0000;
  localparam logic [15:0] SFR1_HI  = 16'h003f;
  localparam logic [15:0] RAM_LO   = 16'h0040;
  localparam logic [15:0] RAM_HI   = 16'h083f;
  localparam logic [15:0] SFR3_LO  = 16'h0e40;
  localparam logic [15:0] SFR3_HI  = 16'h0eff;
  localparam logic [15:0] SFR2_LO  = 16'h0f00;
  localparam logic [15:0] SFR2_HI  = 16'h0fff;
  localparam logic [15:0] BOOT_LO  = 16'h1000;
  localparam logic [15:0] BOOT_HI  = 16'h17ff;
  localparam logic [15:0] FLASH_LO = 16'h8000;
  localparam logic [15:0] VCALL_LO = 16'hffa0;
  localparam logic [15:0] VCALL_HI = 16'hffbf;
  localparam logic [15:0] VINT_LO  = 16'hffcc;
  localparam logic [15:0] VINT_HI  = 16'hfffd;
  localparam logic [7:0]  VEC_RAM_PAGE = 8'h01;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [5:0] {
    TGT_NONE  = 6'h01,
    TGT_RAM   = 6'h02,
    TGT_BOOT  = 6'h04,
    TGT_FLASH = 6'h08,
    TGT_SFR   = 6'h10,
    TGT_SWI   = 6'h20
  } target_e;

  typedef struct packed {
    target_e     target;
    logic [15:0] addr;
  } map_hit_s;

  typedef struct packed {
    logic ram_code;
    logic vec_reloc;
    logic boot_map;
    logic serial_mode;
  } map_cfg_s;

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

endpackage

// ===== rtl/code_map_decode.sv
// Code area decoder: target memory and translated fetch address
`timescale 1ns/1ps
module code_map_decode
  import memmap_pkg::*;
#(
  parameter logic [15:0] FLASH_BASE     = FLASH_LO,
  parameter logic [15:0] BOOT_SERIAL_HI = 16'h1fff
)(
  input  wire logic [15:0] addr,
  input  wire map_cfg_s    cfg,
  output map_hit_s         hit
);
  logic [15:0] boot_top;

  always_comb
  begin
    boot_top   = cfg.serial_mode ? BOOT_SERIAL_HI : BOOT_HI;
    hit.addr   = addr;
    hit.target = TGT_NONE;
    // Reset vector stays outside both tables, never relocated
    if (cfg.vec_reloc && (in_range(addr, VCALL_LO, VCALL_HI) ||
                          in_range(addr, VINT_LO, VINT_HI)))
    begin
      hit.addr   = {VEC_RAM_PAGE, addr[7:0]};
      hit.target = TGT_RAM;
    end
    else if (in_range(addr, RAM_LO, RAM_HI))
      hit.target = (cfg.ram_code || cfg.serial_mode) ? TGT_RAM
                                                     : TGT_SWI;
    else if (in_range(addr, BOOT_LO, boot_top))
    begin
      if (cfg.boot_map)
        hit.target = TGT_BOOT;
      else
        hit.target = (addr >= FLASH_BASE) ? TGT_FLASH : TGT_SWI;
    end
    else if (addr >= FLASH_BASE)
      hit.target = TGT_FLASH;
  end
endmodule

// ===== rtl/data_map_decode.sv
// Data area decoder: register windows, RAM, boot ROM and Flash
`timescale 1ns/1ps
module data_map_decode
  import memmap_pkg::*;
#(
  parameter logic [15:0] FLASH_BASE     = FLASH_LO,
  parameter logic [15:0] BOOT_SERIAL_HI = 16'h1fff
)(
  input  wire logic [15:0] addr,
  input  wire map_cfg_s    cfg,
  output map_hit_s         hit
);
  logic [15:0] boot_top;

  always_comb
  begin
    boot_top   = cfg.serial_mode ? BOOT_SERIAL_HI : BOOT_HI;
    hit.addr   = addr;
    hit.target = TGT_NONE;
    if (in_range(addr, SFR1_LO, SFR1_HI) ||
        in_range(addr, SFR3_LO, SFR3_HI) ||
        in_range(addr, SFR2_LO, SFR2_HI))
      hit.target = TGT_SFR;
    else if (in_range(addr, RAM_LO, RAM_HI))
      hit.target = TGT_RAM;
    else if (cfg.boot_map && in_range(addr, BOOT_LO, boot_top))
      hit.target = TGT_BOOT;
    else if (addr >= FLASH_BASE)
      hit.target = TGT_FLASH;
  end
endmodule

// ===== rtl/memory_map_remap_control.sv
// Memory map remap control: key-committed map settings and decoders
//
// Functional notes
// - Data RAM window decoded from reset
// - Committed flag maps RAM into code area
// - Map bits take effect only on key
// - Unmapped code RAM window fetches trap opcode
// - Serial programming forces RAM into code
// - Unrelocated vectors come from top table
// - Relocated vectors come from RAM page
// - Reset vector never relocated
// - Key commits reset source disable
// - Key commits reset flag clear control
// - Key write-only; reads return commit status
// - Status shows effective map bits, zeros above
// - Boot ROM hidden after reset
// - Committed boot flag maps boot ROM window
// - Flash control write lands in holding copy
// - Working flash control copy readable separately
// - Only first boot ROM block outside serial
// - Hidden boot window fetch gives Flash or trap
// - Code Flash window decoded from reset
// - Data register windows decoded from reset
// - Code and data areas decoded independently
`timescale 1ns/1ps
module memory_map_remap_control
  import memmap_pkg::*;
#(
  parameter logic [15:0] FLASH_BASE     = FLASH_LO,
  parameter logic [15:0] BOOT_SERIAL_HI = 16'h1fff
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        serial_prog_mode,
  input  wire logic [15:0] code_addr,
  output map_hit_s         code_hit,
  input  wire logic [15:0] data_addr,
  output map_hit_s         data_hit,
  output logic             reset_source_disable,
  output logic             reset_flag_clear
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [2:0]  ram_map_control;
  logic [2:0]  next_ram_map_control;
  logic        ram_code_map_state;
  logic        next_ram_code_map_state;
  logic        vector_relocate_state;
  logic        next_vector_relocate_state;
  logic        next_reset_source_disable;
  logic        internal_reset_status;
  logic        next_internal_reset_status;
  logic        next_reset_flag_clear;
  logic [7:0]  flash_ctrl_one;
  logic [7:0]  next_flash_ctrl_one;
  logic [7:0]  flash_ctrl_shadow_view;
  logic [7:0]  next_flash_ctrl_shadow_view;

  // ************************************************************
  // Bus channel state
  // ************************************************************
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [31:0] next_rdata;
  logic        wr_fire;
  logic        rd_fire;
  logic [13:0] wr_idx;
  logic [13:0] rd_idx;
  logic        wr_ok;
  logic        rd_ok;
  logic        wr_byte;
  logic [7:0]  wbyte;
  logic [7:0]  map_commit_status;
  map_cfg_s    cfg;

  function automatic logic reg_known(input logic [13:0] idx);
    reg_known = (idx == IDX_FLASH_CTRL_ONE) ||
                (idx == IDX_FLASH_CTRL_COMMIT) ||
                (idx == IDX_RAM_MAP_CONTROL) ||
                (idx == IDX_MAP_COMMIT_KEY) ||
                (idx == IDX_RESET_STATUS) ||
                (idx == IDX_SHADOW_VIEW);
  endfunction

  // ************************************************************
  // Handshakes
  // ************************************************************
  // Address and data are taken together so a write is never split
  assign wr_fire = awvalid && wvalid && !bvalid;
  assign awready = wr_fire;
  assign wready  = wr_fire;
  assign rd_fire = arvalid && !rvalid;
  assign arready = !rvalid;
  assign wr_idx  = awaddr[15:2];
  assign rd_idx  = araddr[15:2];
  assign wr_ok   = (awaddr[1:0] == 2'h0) && reg_known(wr_idx);
  assign rd_ok   = (araddr[1:0] == 2'h0) && reg_known(rd_idx);
  assign wr_byte = wr_fire && wr_ok && wstrb[0];
  assign wbyte   = wdata[7:0];

  assign map_commit_status = {5'h00, vector_relocate_state,
                              ram_code_map_state,
                              reset_source_disable};

  // ************************************************************
  // Configuration registers and key commits
  // ************************************************************
  always_comb
  begin
    next_ram_map_control        = ram_map_control;
    next_ram_code_map_state     = ram_code_map_state;
    next_vector_relocate_state  = vector_relocate_state;
    next_reset_source_disable   = reset_source_disable;
    next_internal_reset_status  = internal_reset_status;
    next_reset_flag_clear       = reset_flag_clear;
    next_flash_ctrl_one         = flash_ctrl_one;
    next_flash_ctrl_shadow_view = flash_ctrl_shadow_view;
    if (wr_byte)
    begin
      if (wr_idx == IDX_RAM_MAP_CONTROL)
        next_ram_map_control = wbyte[2:0];
      else if (wr_idx == IDX_RESET_STATUS)
        next_internal_reset_status = wbyte[IRS_FLAG_CLR_BIT];
      else if (wr_idx == IDX_FLASH_CTRL_ONE)
        next_flash_ctrl_one = wbyte;
      else if (wr_idx == IDX_FLASH_CTRL_COMMIT)
      begin
        if (wbyte == KEY_FLASH_COMMIT)
          next_flash_ctrl_shadow_view = flash_ctrl_one;
      end
      else if (wr_idx == IDX_MAP_COMMIT_KEY)
      begin
        // Any other byte leaves every committed setting alone
        if (wbyte == KEY_MAP_COMMIT)
        begin
          next_ram_code_map_state =
            ram_map_control[RMC_RAM_CODE_BIT];
          next_vector_relocate_state =
            ram_map_control[RMC_VEC_BIT];
        end
        else if (wbyte == KEY_RST_DISABLE)
          next_reset_source_disable =
            ram_map_control[RMC_RST_DIS_BIT];
        else if (wbyte == KEY_FLAG_CLEAR)
          next_reset_flag_clear = internal_reset_status;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ram_map_control        <= RMC_RESET[2:0];
      ram_code_map_state     <= RMC_RESET[RMC_RAM_CODE_BIT];
      vector_relocate_state  <= RMC_RESET[RMC_VEC_BIT];
      reset_source_disable   <= RMC_RESET[RMC_RST_DIS_BIT];
      internal_reset_status  <= IRS_RESET[IRS_FLAG_CLR_BIT];
      reset_flag_clear       <= IRS_RESET[IRS_FLAG_CLR_BIT];
      flash_ctrl_one         <= FC1_RESET;
      flash_ctrl_shadow_view <= FC1_RESET;
    end
    else
    begin
      ram_map_control        <= next_ram_map_control;
      ram_code_map_state     <= next_ram_code_map_state;
      vector_relocate_state  <= next_vector_relocate_state;
      reset_source_disable   <= next_reset_source_disable;
      internal_reset_status  <= next_internal_reset_status;
      reset_flag_clear       <= next_reset_flag_clear;
      flash_ctrl_one         <= next_flash_ctrl_one;
      flash_ctrl_shadow_view <= next_flash_ctrl_shadow_view;
    end
  end

  // ************************************************************
  // Write response and read data
  // ************************************************************
  always_comb
  begin
    next_bvalid = bvalid;
    next_bresp  = bresp;
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_bvalid = 1'b1;
      next_bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = 32'h0000_0000;
      if (rd_idx == IDX_RAM_MAP_CONTROL)
        next_rdata[2:0] = ram_map_control;
      else if (rd_idx == IDX_MAP_COMMIT_KEY)
        next_rdata[7:0] = map_commit_status;
      else if (rd_idx == IDX_FLASH_CTRL_ONE)
        next_rdata[7:0] = flash_ctrl_one;
      else if (rd_idx == IDX_SHADOW_VIEW)
        next_rdata[7:0] = flash_ctrl_shadow_view;
      else if (rd_idx == IDX_RESET_STATUS)
        next_rdata[IRS_FLAG_CLR_BIT] = internal_reset_status;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= 32'h0000_0000;
    end
    else
    begin
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  // ************************************************************
  // Address decoders
  // ************************************************************
  // Two decoders so fetch and data never share a path
  assign cfg.ram_code    = ram_code_map_state;
  assign cfg.vec_reloc   = vector_relocate_state;
  assign cfg.boot_map    = flash_ctrl_shadow_view[FC1_BOOT_BIT];
  assign cfg.serial_mode = serial_prog_mode;

  code_map_decode #(
    .FLASH_BASE     (FLASH_BASE),
    .BOOT_SERIAL_HI (BOOT_SERIAL_HI)
  ) u_code (
    .addr (code_addr),
    .cfg  (cfg),
    .hit  (code_hit)
  );

  data_map_decode #(
    .FLASH_BASE     (FLASH_BASE),
    .BOOT_SERIAL_HI (BOOT_SERIAL_HI)
  ) u_data (
    .addr (data_addr),
    .cfg  (cfg),
    .hit  (data_hit)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_key_write(logic [7:0] key);
    wr_byte && (wr_idx == IDX_MAP_COMMIT_KEY) && (wbyte == key);
  endsequence

  sequence s_plain_write;
    !(wr_byte && (wr_idx == IDX_MAP_COMMIT_KEY));
  endsequence

  a_ram_data_map: assert property (
    in_range(data_addr, RAM_LO, RAM_HI) |-> data_hit.target == TGT_RAM)
    else $error("data RAM window not decoded to RAM");

  a_map_key_gate: assert property (
    s_plain_write |=> $stable(ram_code_map_state) &&
                      $stable(vector_relocate_state))
    else $error("map state changed without key");

  a_map_key_take: assert property (
    s_key_write(KEY_MAP_COMMIT) |=>
      ram_code_map_state == $past(ram_map_control[RMC_RAM_CODE_BIT]) &&
      vector_relocate_state == $past(ram_map_control[RMC_VEC_BIT]))
    else $error("map key did not commit held bits");

  a_swi_fetch: assert property (
    !ram_code_map_state && !serial_prog_mode &&
    in_range(code_addr, RAM_LO, RAM_HI) |-> code_hit.target == TGT_SWI)
    else $error("unmapped RAM fetch not trapped");

  a_serial_ram: assert property (
    serial_prog_mode && in_range(code_addr, RAM_LO, RAM_HI)
      |-> code_hit.target == TGT_RAM)
    else $error("serial mode fetch not from RAM");

  a_vec_reloc: assert property (
    vector_relocate_state && in_range(code_addr, VINT_LO, VINT_HI)
      |-> code_hit.target == TGT_RAM &&
          code_hit.addr == {VEC_RAM_PAGE, code_addr[7:0]})
    else $error("relocated vector not in RAM page");

  a_reset_vector: assert property (
    code_addr > VINT_HI |-> code_hit.addr == code_addr &&
                            code_hit.target == TGT_FLASH)
    else $error("reset vector moved");

  a_other_key: assert property (
    wr_byte && wr_idx == IDX_MAP_COMMIT_KEY &&
    wbyte != KEY_MAP_COMMIT && wbyte != KEY_RST_DISABLE &&
    wbyte != KEY_FLAG_CLEAR |=> $stable(map_commit_status) &&
                                $stable(reset_flag_clear))
    else $error("unknown key changed committed state");

  a_rst_dis_key: assert property (
    s_key_write(KEY_RST_DISABLE) ##1 s_plain_write [*2]
      |-> reset_source_disable ==
          $past(ram_map_control[RMC_RST_DIS_BIT], 2))
    else $error("reset disable key did not commit");

  a_status_read: assert property (
    rd_fire && rd_idx == IDX_MAP_COMMIT_KEY &&
    !(wr_byte && (wr_idx == IDX_MAP_COMMIT_KEY))
      |=> rdata == {24'h00_0000, map_commit_status})
    else $error("commit key read not status");

  a_flash_shadow: assert property (
    wr_byte && wr_idx == IDX_FLASH_CTRL_COMMIT &&
    wbyte == KEY_FLASH_COMMIT |=> flash_ctrl_shadow_view ==
                                  $past(flash_ctrl_one))
    else $error("flash commit did not copy holding value");

  a_boot_data: assert property (
    cfg.boot_map && in_range(data_addr, BOOT_LO, BOOT_HI)
      |-> data_hit.target == TGT_BOOT)
    else $error("boot window not decoded to boot ROM");

endmodule

// ===== dv/core_bus_model.sv
// CPU core model: drives fetch and data addresses, samples the decode
`timescale 1ns/1ps
module core_bus_model
  import memmap_pkg::*;
(
  input  wire logic     aclk,
  output logic [15:0]   code_addr,
  output logic [15:0]   data_addr,
  input  wire map_hit_s code_hit,
  input  wire map_hit_s data_hit
);
  initial
  begin
    code_addr = 16'h0000;
    data_addr = 16'h0000;
  end

  // Address moves after an edge, decode taken one edge later
  task automatic look(input logic [15:0] ca, input logic [15:0] da,
                      output map_hit_s ch, output map_hit_s dh);
    @(posedge aclk);
    code_addr <= ca;
    data_addr <= da;
    @(posedge aclk);
    ch = code_hit;
    dh = data_hit;
  endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the memory map remap control block
`timescale 1ns/1ps
module tb_top
  import memmap_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rsd, rfc, sp;
  logic [15:0] awaddr, araddr, code_addr, data_addr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  map_hit_s    code_hit, data_hit, ch, dh;
  int          bad_count, num_checks;

  always #2.5 aclk = ~aclk;

  memory_map_remap_control memory_map_remap_control_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_prog_mode(sp), .code_addr(code_addr), .code_hit(code_hit),
    .data_addr(data_addr), .data_hit(data_hit),
    .reset_source_disable(rsd), .reset_flag_clear(rfc));

  core_bus_model core_bus_model_inst (.aclk(aclk), .code_addr(code_addr),
    .data_addr(data_addr), .code_hit(code_hit), .data_hit(data_hit));

  // ******************************
  // Reporting and bus tasks
  // ******************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_tgt(input map_hit_s got, input target_e exp);
    num_checks++;
    if (got.target !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got.target, exp);
    end
  endtask

  // Every wait is bounded so a dead handshake cannot hang the run
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 64)
    begin
      bad_count++;
      $display("[ERR] t=%0t timeout got %h exp %h", $time, n, 0);
      close_out();
    end
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do tick(n); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do tick(n); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [13:0] idx, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do tick(n); while (!arready);
    arvalid <= 1'b0;
    do tick(n); while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic look(input logic [15:0] ca, input logic [15:0] da);
    core_bus_model_inst.look(ca, da, ch, dh);
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic t_reset;
    rd_reg(IDX_MAP_COMMIT_KEY, rd);
    chk_val(rd, 32'h0000_0000);
    rd_reg(IDX_FLASH_CTRL_ONE, rd);
    chk_val(rd, {24'h00_0000, FC1_RESET});
    look(16'h0040, 16'h0040);
    chk_tgt(ch, TGT_SWI);
    chk_tgt(dh, TGT_RAM);
    look(16'h8000, 16'h0000);
    chk_tgt(ch, TGT_FLASH);
    chk_tgt(dh, TGT_SFR);
    look(16'hffa0, 16'h0f00);
    chk_tgt(ch, TGT_FLASH);
    chk_val({16'h0000, ch.addr}, 32'h0000_ffa0);
    chk_tgt(dh, TGT_SFR);
    look(16'h1000, 16'h0e40);
    chk_tgt(ch, TGT_SWI);
    chk_tgt(dh, TGT_SFR);
    $display("test reset done");
  endtask

  task automatic t_map;
    wr(IDX_RAM_MAP_CONTROL, 8'h06); // Both bits set before commit
    look(16'h083f, 16'h083f);
    chk_tgt(ch, TGT_SWI);
    chk_tgt(dh, TGT_RAM);
    wr(IDX_MAP_COMMIT_KEY, 8'h55);
    rd_reg(IDX_MAP_COMMIT_KEY, rd);
    chk_val(rd, 32'h0000_0000);
    wr(IDX_MAP_COMMIT_KEY, KEY_MAP_COMMIT);
    rd_reg(IDX_MAP_COMMIT_KEY, rd);
    chk_val(rd, 32'h0000_0006);
    look(16'h083f, 16'h0040);
    chk_tgt(ch, TGT_RAM);
    look(16'hfffd, 16'h0040);
    chk_val({16'h0000, ch.addr}, 32'h0000_01fd);
    look(16'hffa0, 16'h0040);
    chk_tgt(ch, TGT_RAM);
    chk_val({16'h0000, ch.addr}, 32'h0000_01a0);
    look(16'hfffe, 16'h0040);
    chk_val({16'h0000, ch.addr}, 32'h0000_fffe);
    chk_tgt(ch, TGT_FLASH);
    // Relocation left set, never cleared by the loader
    $display("test map done");
  endtask

  task automatic t_serial;
    do_reset();
    sp <= 1'b1;
    look(16'h0040, 16'h0040);
    chk_tgt(ch, TGT_RAM);
    // Serial mode widens the boot window; unmapped it traps below Flash
    look(16'h1800, 16'h0040);
    chk_tgt(ch, TGT_SWI);
    sp <= 1'b0;
    $display("test serial done");
  endtask

  task automatic t_boot;
    wr(IDX_FLASH_CTRL_ONE, 8'h48);
    rd_reg(IDX_SHADOW_VIEW, rd);
    chk_val(rd, {24'h00_0000, FC1_RESET});
    look(16'h1000, 16'h1000);
    chk_tgt(dh, TGT_NONE);
    wr(IDX_FLASH_CTRL_COMMIT, KEY_FLASH_COMMIT);
    rd_reg(IDX_SHADOW_VIEW, rd);
    chk_val(rd, 32'h0000_0048);
    look(16'h17ff, 16'h1000);
    chk_tgt(ch, TGT_BOOT);
    chk_tgt(dh, TGT_BOOT);
    look(16'h1800, 16'h1800);
    chk_tgt(ch, TGT_NONE);
    chk_tgt(dh, TGT_NONE);
    $display("test boot done");
  endtask

  task automatic t_keys;
    wr(IDX_RAM_MAP_CONTROL, 8'h01);
    chk_val({31'h0, rsd}, 32'h0000_0000);
    wr(IDX_MAP_COMMIT_KEY, KEY_RST_DISABLE);
    chk_val({31'h0, rsd}, 32'h0000_0001);
    wr(IDX_RESET_STATUS, 8'h01);
    chk_val({31'h0, rfc}, 32'h0000_0000);
    wr(IDX_MAP_COMMIT_KEY, KEY_FLAG_CLEAR);
    chk_val({31'h0, rfc}, 32'h0000_0001);
    wr(14'h0fd5, 8'h00);
    chk_val({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd_reg(14'h0fd5, rd);
    chk_val({30'h0, resp}, {30'h0, RESP_SLVERR});
    chk_val(rd, 32'h0000_0000);
    $display("test keys done");
  endtask

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, sp} = 6'h00;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    bad_count = 0;
    num_checks = 0;
    do_reset();
    t_reset();
    t_map();
    t_serial();
    t_boot();
    t_keys();
    close_out();
  end
endmodule
